// File: include/csm_defs.svh
// object indices, reset values, mode codes and timing for the cyclic setpoint block
`ifndef CSM_DEFS_SVH
`define CSM_DEFS_SVH
`define CSM_IDX_CTRL      16'h6040
`define CSM_IDX_STAT      16'h6041
`define CSM_IDX_QS_OPT    16'h605a
`define CSM_IDX_MODE      16'h6060
`define CSM_IDX_ACT_POS   16'h6064
`define CSM_IDX_FE_WIN    16'h6065
`define CSM_IDX_FE_TO     16'h6066
`define CSM_IDX_ACT_VEL   16'h606c
`define CSM_IDX_TRQ_SP    16'h6071
`define CSM_IDX_MAX_TRQ   16'h6072
`define CSM_IDX_MAX_CUR   16'h6073
`define CSM_IDX_POS_SP    16'h607a
`define CSM_IDX_RANGE     16'h607b
`define CSM_IDX_SW_LIM    16'h607d
`define CSM_IDX_MAX_SPD   16'h6080
`define CSM_IDX_QS_DEC    16'h6085
`define CSM_IDX_IP_TIME   16'h60c2
`define CSM_IDX_FE_ACT    16'h60f4
`define CSM_IDX_VEL_SP    16'h60ff
`define CSM_SUB_0         8'h00
`define CSM_SUB_1         8'h01
`define CSM_SUB_2         8'h02
`define CSM_MODE_POS      8'h08
`define CSM_MODE_VEL      8'h09
`define CSM_MODE_TRQ      8'h0a
`define CSM_IP_IDX_MS     8'hfd
`define CSM_RST_IP_PER    8'h01
`define CSM_RST_MIN       32'h80000000
`define CSM_RST_MAX       32'h7fffffff
`define CSM_RST_U16_MAX   16'hffff
`define CSM_BIT_SYNC      8
`define CSM_BIT_LIMIT     11
`define CSM_BIT_FOLLOW    12
`define CSM_BIT_FERR      13
`define CSM_CLK_KHZ       25000
`define CSM_BASE_MS       1
`define CSM_MS_CYCLES     (`CSM_BASE_MS * `CSM_CLK_KHZ)
`endif

// File: include/csm_pkg.sv
// types shared by the cyclic setpoint block
package csm_pkg;
  typedef enum logic [1:0] {CSM_NONE, CSM_POS, CSM_VEL, CSM_TRQ} csm_mode_t;
endpackage

// File: hdl/csm_tick.sv
// one-millisecond enable pulse divided from the system clock
`timescale 1ns/1ps
module csm_tick
  import csm_pkg::*;
#(
  parameter int MS_CYCLES = 25000
)
(
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  output logic      ms_tick_out
);
  typedef struct packed
  {
    logic [15:0] cnt;
    logic        tick;
  } csm_tick_st_t;

  localparam logic [15:0] LAST = 16'(MS_CYCLES - 1);

  csm_tick_st_t st;
  csm_tick_st_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == LAST)
    begin
      next_st.cnt = 16'h0;
      next_st.tick = 1'b1;
    end
    else
    begin
      next_st.cnt = st.cnt + 16'h1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      st <= '0;
    else
      st <= next_st;
  end

  assign ms_tick_out = st.tick;
endmodule

// File: hdl/csm_buf.sv
// two-entry setpoint buffer with valid and ready on both sides
`timescale 1ns/1ps
module csm_buf
  import csm_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        in_valid_in,
  input  wire logic [33:0] in_data_in,
  output logic             in_ready_out,
  output logic             out_valid_out,
  output logic [33:0]      out_data_out,
  input  wire logic        out_ready_in
);
  typedef struct packed
  {
    logic [1:0][33:0] mem;
    logic [1:0]       cnt;
  } csm_buf_st_t;

  csm_buf_st_t st;
  csm_buf_st_t next_st;
  logic        push;
  logic        pop;

  assign in_ready_out  = (st.cnt != 2'h2);
  assign out_valid_out = (st.cnt != 2'h0);
  assign out_data_out  = st.mem[0];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_comb
  begin
    next_st = st;
    if (pop)
    begin
      next_st.mem[0] = st.mem[1];
    end
    if (push)
    begin
      if (st.cnt == 2'h0 || (st.cnt == 2'h1 && pop))
        next_st.mem[0] = in_data_in;
      else
        next_st.mem[1] = in_data_in;
    end
    next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      st <= '0;
    else
      st <= next_st;
  end
endmodule

// File: hdl/csm_core.sv
// cyclic synchronous position, velocity and torque setpoint handling
//
// Summary of operation
// - mode value 8 selects cyclic position
// - mode value 9 selects cyclic velocity
// - mode value 10 selects cyclic torque
// - no ramps; each setpoint passed on directly
// - absolute target; repeats within cycle harmless
// - position targets need no control bit 4
// - control bits carry no mode meaning
// - status bit 8 shows fieldbus sync
// - position: bit 12 gates target use
// - velocity: bit 12 gates target use
// - torque: bit 12 gates target use
// - status bit 11 flags software limit
// - status bit 13 flags timed following error
// - following error timeout counts milliseconds
// - cycle time is period times ten-power index
// - only index -3, one millisecond base
// - position setpoint confined to software limits
// - range overrun wraps within position range
// - quick stop hands deceleration and option on
// - torque mode needs closed loop active
// - actual position, velocity, error are readable
// - torque limited by smaller of two maxima
`timescale 1ns/1ps
`include "csm_defs.svh"
module csm_core
  import csm_pkg::*;
#(
  parameter int MS_CYCLES = `CSM_MS_CYCLES
)
(
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic [15:0] obj_index_in,
  input  wire logic [7:0]  obj_sub_in,
  input  wire logic        obj_wr_in,
  input  wire logic        obj_rd_in,
  input  wire logic [31:0] obj_wdata_in,
  output logic [31:0]      obj_rdata_out,
  output logic             obj_ack_out,
  output logic             obj_err_out,
  input  wire logic        sync_in,
  input  wire logic        op_enabled_in,
  input  wire logic        closed_loop_in,
  input  wire logic        quick_stop_in,
  input  wire logic [31:0] act_pos_in,
  input  wire logic [31:0] act_vel_in,
  output logic [15:0]      status_word_out,
  output logic [15:0]      control_word_out,
  output logic             sp_valid_out,
  output logic [1:0]       sp_mode_out,
  output logic [31:0]      sp_value_out,
  input  wire logic        sp_ready_in,
  output logic             qs_active_out,
  output logic [31:0]      qs_decel_out,
  output logic [15:0]      qs_option_out
);
  typedef struct packed
  {
    logic [15:0] ctrl;
    logic [7:0]  mode_sel;
    logic [31:0] fe_win;
    logic [15:0] fe_to;
    logic [15:0] trq_sp;
    logic [31:0] pos_sp;
    logic [31:0] vel_sp;
    logic [31:0] rng_min;
    logic [31:0] rng_max;
    logic [31:0] sw_min;
    logic [31:0] sw_max;
    logic [31:0] qs_dec;
    logic [15:0] qs_opt;
    logic [15:0] max_trq;
    logic [15:0] max_cur;
    logic [31:0] max_spd;
    logic [7:0]  ip_per;
    logic [7:0]  ip_idx;
    logic [15:0] ms_since;
    logic        in_sync;
    logic [31:0] dem_pos;
    logic        lim_hit;
    logic [15:0] fe_cnt;
    logic        fe_flag;
    logic        push_v;
    logic [33:0] push_data;
    logic [31:0] rdata;
    logic        ack;
    logic        err;
  } csm_core_st_t;

  csm_core_st_t st;
  csm_core_st_t next_st;
  logic         ms_tick;
  logic         buf_ready;
  logic [33:0]  buf_data;
  csm_mode_t    mode;
  logic         follow;
  logic [31:0]  fe_act;
  logic [31:0]  fe_abs;
  logic         outside;
  logic [31:0]  pos_wrapped;
  logic [15:0]  trq_lim;
  logic [31:0]  sel_sp;

  function automatic logic [31:0] clamp(input logic [31:0] v,
                                        input logic [31:0] lo,
                                        input logic [31:0] hi);
    if ($signed(v) < $signed(lo))
      return lo;
    else if ($signed(v) > $signed(hi))
      return hi;
    else
      return v;
  endfunction

  function automatic logic [31:0] wrap(input logic [31:0] v,
                                       input logic [31:0] lo,
                                       input logic [31:0] hi);
    logic [31:0] span;
    span = hi - lo + 32'h1;
    if ($signed(lo) >= $signed(hi))
      return v;
    else if ($signed(v) > $signed(hi))
      return v - span;
    else if ($signed(v) < $signed(lo))
      return v + span;
    else
      return v;
  endfunction

  function automatic csm_mode_t decode_mode(input logic [7:0] sel,
                                            input logic       closed);
    if (sel == `CSM_MODE_POS)
      return CSM_POS;
    else if (sel == `CSM_MODE_VEL)
      return CSM_VEL;
    else if (sel == `CSM_MODE_TRQ && closed)
      return CSM_TRQ;
    else
      return CSM_NONE;
  endfunction

  csm_tick #(
    .MS_CYCLES (MS_CYCLES)
  ) u_tick (
    .clock_in    (clock_in),
    .rst_n_in    (rst_n_in),
    .ms_tick_out (ms_tick)
  );

  csm_buf u_buf (
    .clock_in      (clock_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (st.push_v),
    .in_data_in    (st.push_data),
    .in_ready_out  (buf_ready),
    .out_valid_out (sp_valid_out),
    .out_data_out  (buf_data),
    .out_ready_in  (sp_ready_in)
  );

  // mode and follow status; control word bits take no part here
  assign mode    = decode_mode(st.mode_sel, closed_loop_in);
  assign follow  = st.in_sync && mode != CSM_NONE && op_enabled_in
                   && !quick_stop_in;
  assign fe_act  = act_pos_in - st.dem_pos;
  assign fe_abs  = fe_act[31] ? (32'h0 - fe_act) : fe_act;
  assign outside = fe_abs > st.fe_win;
  assign pos_wrapped = wrap(st.pos_sp, st.rng_min, st.rng_max);
  assign trq_lim = (st.max_trq < st.max_cur) ? st.max_trq : st.max_cur;

  always_comb
  begin
    unique case (mode)
      CSM_POS: sel_sp = clamp(pos_wrapped, st.sw_min, st.sw_max);
      CSM_VEL: sel_sp = clamp(st.vel_sp, 32'h0 - st.max_spd, st.max_spd);
      CSM_TRQ: sel_sp = clamp({{16{st.trq_sp[15]}}, st.trq_sp},
                              32'h0 - {16'h0, trq_lim}, {16'h0, trq_lim});
      CSM_NONE: sel_sp = 32'h0;
    endcase
  end

  always_comb
  begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.err = 1'b0;

    // object writes; setpoints simply overwrite, last one per cycle wins
    if (obj_wr_in)
    begin
      next_st.ack = 1'b1;
      unique case ({obj_index_in, obj_sub_in})
        {`CSM_IDX_CTRL, `CSM_SUB_0}: next_st.ctrl = obj_wdata_in[15:0];
        {`CSM_IDX_MODE, `CSM_SUB_0}: next_st.mode_sel = obj_wdata_in[7:0];
        {`CSM_IDX_FE_WIN, `CSM_SUB_0}: next_st.fe_win = obj_wdata_in;
        {`CSM_IDX_FE_TO, `CSM_SUB_0}: next_st.fe_to = obj_wdata_in[15:0];
        {`CSM_IDX_TRQ_SP, `CSM_SUB_0}: next_st.trq_sp = obj_wdata_in[15:0];
        {`CSM_IDX_POS_SP, `CSM_SUB_0}: next_st.pos_sp = obj_wdata_in;
        {`CSM_IDX_VEL_SP, `CSM_SUB_0}: next_st.vel_sp = obj_wdata_in;
        {`CSM_IDX_RANGE, `CSM_SUB_1}: next_st.rng_min = obj_wdata_in;
        {`CSM_IDX_RANGE, `CSM_SUB_2}: next_st.rng_max = obj_wdata_in;
        {`CSM_IDX_SW_LIM, `CSM_SUB_1}: next_st.sw_min = obj_wdata_in;
        {`CSM_IDX_SW_LIM, `CSM_SUB_2}: next_st.sw_max = obj_wdata_in;
        {`CSM_IDX_QS_DEC, `CSM_SUB_0}: next_st.qs_dec = obj_wdata_in;
        {`CSM_IDX_QS_OPT, `CSM_SUB_0}: next_st.qs_opt = obj_wdata_in[15:0];
        {`CSM_IDX_MAX_TRQ, `CSM_SUB_0}: next_st.max_trq = obj_wdata_in[15:0];
        {`CSM_IDX_MAX_CUR, `CSM_SUB_0}: next_st.max_cur = obj_wdata_in[15:0];
        {`CSM_IDX_MAX_SPD, `CSM_SUB_0}: next_st.max_spd = obj_wdata_in;
        {`CSM_IDX_IP_TIME, `CSM_SUB_1}: next_st.ip_per = obj_wdata_in[7:0];
        {`CSM_IDX_IP_TIME, `CSM_SUB_2}:
        begin
          if (obj_wdata_in[7:0] != `CSM_IP_IDX_MS)
            next_st.err = 1'b1;
        end
        default: next_st.err = 1'b1;
      endcase
    end
    else if (obj_rd_in)
    begin
      next_st.ack = 1'b1;
      next_st.rdata = 32'h0;
      unique case ({obj_index_in, obj_sub_in})
        {`CSM_IDX_CTRL, `CSM_SUB_0}: next_st.rdata = {16'h0, st.ctrl};
        {`CSM_IDX_STAT, `CSM_SUB_0}: next_st.rdata = {16'h0, status_word_out};
        {`CSM_IDX_MODE, `CSM_SUB_0}: next_st.rdata = {24'h0, st.mode_sel};
        {`CSM_IDX_ACT_POS, `CSM_SUB_0}: next_st.rdata = act_pos_in;
        {`CSM_IDX_ACT_VEL, `CSM_SUB_0}: next_st.rdata = act_vel_in;
        {`CSM_IDX_FE_ACT, `CSM_SUB_0}: next_st.rdata = fe_act;
        {`CSM_IDX_FE_WIN, `CSM_SUB_0}: next_st.rdata = st.fe_win;
        {`CSM_IDX_FE_TO, `CSM_SUB_0}: next_st.rdata = {16'h0, st.fe_to};
        {`CSM_IDX_TRQ_SP, `CSM_SUB_0}: next_st.rdata = {16'h0, st.trq_sp};
        {`CSM_IDX_POS_SP, `CSM_SUB_0}: next_st.rdata = st.pos_sp;
        {`CSM_IDX_VEL_SP, `CSM_SUB_0}: next_st.rdata = st.vel_sp;
        {`CSM_IDX_RANGE, `CSM_SUB_1}: next_st.rdata = st.rng_min;
        {`CSM_IDX_RANGE, `CSM_SUB_2}: next_st.rdata = st.rng_max;
        {`CSM_IDX_SW_LIM, `CSM_SUB_1}: next_st.rdata = st.sw_min;
        {`CSM_IDX_SW_LIM, `CSM_SUB_2}: next_st.rdata = st.sw_max;
        {`CSM_IDX_QS_DEC, `CSM_SUB_0}: next_st.rdata = st.qs_dec;
        {`CSM_IDX_QS_OPT, `CSM_SUB_0}: next_st.rdata = {16'h0, st.qs_opt};
        {`CSM_IDX_MAX_TRQ, `CSM_SUB_0}: next_st.rdata = {16'h0, st.max_trq};
        {`CSM_IDX_MAX_CUR, `CSM_SUB_0}: next_st.rdata = {16'h0, st.max_cur};
        {`CSM_IDX_MAX_SPD, `CSM_SUB_0}: next_st.rdata = st.max_spd;
        {`CSM_IDX_IP_TIME, `CSM_SUB_1}: next_st.rdata = {24'h0, st.ip_per};
        {`CSM_IDX_IP_TIME, `CSM_SUB_2}: next_st.rdata = {{24{st.ip_idx[7]}}, st.ip_idx};
        default: next_st.err = 1'b1;
      endcase
    end

    // cycle supervision in whole milliseconds
    if (ms_tick && st.ms_since != 16'hffff)
    begin
      next_st.ms_since = st.ms_since + 16'h1;
    end
    if (sync_in)
    begin
      next_st.ms_since = 16'h0;
      next_st.in_sync = (st.ip_per != 8'h0)
                        && (st.ms_since + 16'h1 >= {8'h0, st.ip_per})
                        && (st.ms_since <= {8'h0, st.ip_per} + 16'h1);
    end
    else if (st.ms_since > {8'h0, st.ip_per} + 16'h1)
    begin
      next_st.in_sync = 1'b0;
    end

    // hand the accepted setpoint on, holding it while the buffer is full
    if (st.push_v && buf_ready)
    begin
      next_st.push_v = 1'b0;
    end
    if (sync_in && follow && !(st.push_v && !buf_ready))
    begin
      next_st.push_v = 1'b1;
      next_st.push_data = {mode, sel_sp};
      if (mode == CSM_POS)
      begin
        next_st.dem_pos = sel_sp;
        next_st.lim_hit = ($signed(pos_wrapped) < $signed(st.sw_min))
                          || ($signed(pos_wrapped) > $signed(st.sw_max));
      end
    end

    // following error corridor in position mode only
    if (mode != CSM_POS)
    begin
      next_st.lim_hit = 1'b0;
      next_st.fe_cnt = 16'h0;
      next_st.fe_flag = 1'b0;
    end
    else if (!outside)
    begin
      next_st.fe_cnt = 16'h0;
      next_st.fe_flag = 1'b0;
    end
    else
    begin
      if (ms_tick && st.fe_cnt != 16'hffff)
      begin
        next_st.fe_cnt = st.fe_cnt + 16'h1;
      end
      if (st.fe_cnt > st.fe_to)
      begin
        next_st.fe_flag = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st <= '0;
      st.rng_min <= `CSM_RST_MIN;
      st.rng_max <= `CSM_RST_MAX;
      st.sw_min <= `CSM_RST_MIN;
      st.sw_max <= `CSM_RST_MAX;
      st.max_trq <= `CSM_RST_U16_MAX;
      st.max_cur <= `CSM_RST_U16_MAX;
      st.max_spd <= `CSM_RST_MAX;
      st.ip_per <= `CSM_RST_IP_PER;
      st.ip_idx <= `CSM_IP_IDX_MS;
      st.ms_since <= `CSM_RST_U16_MAX;
    end
    else
    begin
      st <= next_st;
    end
  end

  always_comb
  begin
    status_word_out = 16'h0;
    status_word_out[`CSM_BIT_SYNC] = st.in_sync;
    status_word_out[`CSM_BIT_LIMIT] = st.lim_hit;
    status_word_out[`CSM_BIT_FOLLOW] = follow;
    status_word_out[`CSM_BIT_FERR] = st.fe_flag;
  end

  // quick stop parameters reach the loop while the stop is requested
  assign qs_active_out    = quick_stop_in;
  assign qs_decel_out     = st.qs_dec;
  assign qs_option_out    = st.qs_opt;
  assign control_word_out = st.ctrl;
  assign sp_mode_out      = buf_data[33:32];
  assign sp_value_out     = buf_data[31:0];
  assign obj_rdata_out    = st.rdata;
  assign obj_ack_out      = st.ack;
  assign obj_err_out      = st.err;
endmodule

// File: verification/csm_core_props.sv
// concurrent checks on the ports of the cyclic setpoint block
`timescale 1ns/1ps
`include "csm_defs.svh"
module csm_core_chk
  import csm_pkg::*;
#(
  parameter int MS_CYCLES = 10
)
(
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  input wire logic [15:0] obj_index_in,
  input wire logic [7:0]  obj_sub_in,
  input wire logic        obj_wr_in,
  input wire logic        obj_rd_in,
  input wire logic [31:0] obj_wdata_in,
  input wire logic [31:0] obj_rdata_out,
  input wire logic        obj_ack_out,
  input wire logic        obj_err_out,
  input wire logic        sync_in,
  input wire logic        op_enabled_in,
  input wire logic        quick_stop_in,
  input wire logic [31:0] act_pos_in,
  input wire logic [15:0] status_word_out,
  input wire logic [15:0] control_word_out,
  input wire logic        sp_valid_out,
  input wire logic [1:0]  sp_mode_out,
  input wire logic [31:0] sp_value_out,
  input wire logic        sp_ready_in,
  input wire logic        qs_active_out,
  input wire logic [31:0] qs_decel_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_strobe;
    obj_wr_in || obj_rd_in;
  endsequence
  sequence s_sync_taken;
    sync_in && status_word_out[`CSM_BIT_FOLLOW] && !sp_valid_out;
  endsequence
  sequence s_ctrl_wr;
    obj_wr_in && obj_index_in == `CSM_IDX_CTRL && obj_sub_in == `CSM_SUB_0;
  endsequence
  a_ack_after_strobe: assert property (s_strobe |=> obj_ack_out)
    else $error("no ack one cycle after strobe");
  a_no_spurious_ack: assert property (!(obj_wr_in || obj_rd_in) |=> !obj_ack_out)
    else $error("ack without strobe");
  a_err_with_ack: assert property (obj_err_out |-> obj_ack_out)
    else $error("err without ack");
  a_quick_stop_pass: assert property (qs_active_out == quick_stop_in)
    else $error("quick stop not passed on");
  a_follow_gate: assert property (status_word_out[`CSM_BIT_FOLLOW] |->
    status_word_out[`CSM_BIT_SYNC] && op_enabled_in && !quick_stop_in)
    else $error("follow bit without its conditions");
  a_sync_push_two: assert property (s_sync_taken |-> ##2 sp_valid_out)
    else $error("setpoint not presented two cycles after sync");
  a_sp_stands: assert property (sp_valid_out && !sp_ready_in |=>
    sp_valid_out && $stable(sp_value_out) && $stable(sp_mode_out))
    else $error("setpoint changed while stalled");
  a_ctrl_stored: assert property (s_ctrl_wr |=>
    control_word_out == $past(obj_wdata_in[15:0]))
    else $error("control word not stored");
  a_qs_decel_wr: assert property (obj_wr_in && obj_index_in == `CSM_IDX_QS_DEC
    && obj_sub_in == `CSM_SUB_0 |=> qs_decel_out == $past(obj_wdata_in))
    else $error("quick stop deceleration not stored");
  a_ro_write_err: assert property (obj_wr_in && obj_index_in == `CSM_IDX_ACT_POS |=>
    obj_err_out)
    else $error("write to read-only object accepted");
  a_ip_idx_err: assert property (obj_wr_in && obj_index_in == `CSM_IDX_IP_TIME
    && obj_sub_in == `CSM_SUB_2 && obj_wdata_in[7:0] != `CSM_IP_IDX_MS |=> obj_err_out)
    else $error("unsupported index accepted");
  a_act_pos_read: assert property (obj_rd_in && !obj_wr_in
    && obj_index_in == `CSM_IDX_ACT_POS && obj_sub_in == `CSM_SUB_0
    |=> obj_rdata_out == $past(act_pos_in))
    else $error("actual position read wrong");
  a_status_spare: assert property (status_word_out[7:0] == 8'h00
    && status_word_out[10:9] == 2'h0 && status_word_out[15:14] == 2'h0)
    else $error("reserved status bits set");
endmodule
bind csm_core csm_core_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.clock_in(clock_in),
  .rst_n_in(rst_n_in), .obj_index_in(obj_index_in), .obj_sub_in(obj_sub_in),
  .obj_wr_in(obj_wr_in), .obj_rd_in(obj_rd_in), .obj_wdata_in(obj_wdata_in),
  .obj_rdata_out(obj_rdata_out), .obj_ack_out(obj_ack_out), .obj_err_out(obj_err_out),
  .sync_in(sync_in), .op_enabled_in(op_enabled_in), .quick_stop_in(quick_stop_in),
  .act_pos_in(act_pos_in), .status_word_out(status_word_out),
  .control_word_out(control_word_out), .sp_valid_out(sp_valid_out),
  .sp_mode_out(sp_mode_out), .sp_value_out(sp_value_out), .sp_ready_in(sp_ready_in),
  .qs_active_out(qs_active_out), .qs_decel_out(qs_decel_out));

// File: verification/csm_fb_master.sv
// fieldbus master model issuing the cyclic sync pulse
`timescale 1ns/1ps
module csm_fb_master
(
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  input  wire logic enable_in,
  input  int        gap_in,
  output logic      sync_out
);
  int cnt;
  // one sync each cycle period while enabled
  always @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt <= 0;
      sync_out <= 1'b0;
    end
    else
    begin
      cnt <= (cnt >= gap_in - 1) ? 0 : cnt + 1;
      sync_out <= #1 enable_in && (cnt == 0);
    end
  end
endmodule

// File: verification/cyclic_sync_setpoint_modes_tb_top.sv
// self-checking bench for the cyclic setpoint block
`timescale 1ns/1ps
`include "csm_defs.svh"
module cyclic_sync_setpoint_modes_tb_top;
  import csm_pkg::*;
  localparam int MSC = 10;
  logic        clock_in, rst_n_in, obj_wr_in, obj_rd_in, sync_in, op_enabled_in;
  logic        closed_loop_in, quick_stop_in, sp_ready_in, obj_ack_out, obj_err_out;
  logic        sp_valid_out, qs_active_out, fb_en;
  logic [15:0] obj_index_in, status_word_out, control_word_out, qs_option_out;
  logic [7:0]  obj_sub_in;
  logic [31:0] obj_wdata_in, obj_rdata_out, act_pos_in, act_vel_in, sp_value_out;
  logic [31:0] qs_decel_out;
  logic [1:0]  sp_mode_out;
  int          n_mismatch, compares, cyc, fb_gap;
  csm_core #(.MS_CYCLES(MSC)) DUT (.clock_in, .rst_n_in, .obj_index_in, .obj_sub_in,
    .obj_wr_in, .obj_rd_in, .obj_wdata_in, .obj_rdata_out, .obj_ack_out, .obj_err_out,
    .sync_in, .op_enabled_in, .closed_loop_in, .quick_stop_in, .act_pos_in, .act_vel_in,
    .status_word_out, .control_word_out, .sp_valid_out, .sp_mode_out, .sp_value_out,
    .sp_ready_in, .qs_active_out, .qs_decel_out, .qs_option_out);
  csm_fb_master u_master (.clock_in(clock_in), .rst_n_in(rst_n_in), .enable_in(fb_en),
    .gap_in(fb_gap), .sync_out(sync_in));
  initial
  begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end
  task report_and_stop;
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
              input logic [31:0] d, input logic exp_err);
    @(posedge clock_in);
    #1;
    obj_wr_in = wr;
    obj_rd_in = ~wr;
    obj_index_in = idx;
    obj_sub_in = sub;
    obj_wdata_in = d;
    @(posedge clock_in);
    #1;
    obj_wr_in = 1'b0;
    obj_rd_in = 1'b0;
    chk("ack", 32'h1, {31'h0, obj_ack_out});
    chk("err", {31'h0, exp_err}, {31'h0, obj_err_out});
  endtask
  task wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
          input logic e);
    access(1'b1, idx, sub, d, e);
  endtask
  task rdc(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
    access(1'b0, idx, sub, 32'h0, 1'b0);
    chk("rdata", exp, obj_rdata_out);
  endtask
  task cycles(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task stat(input int b, input logic v);
    chk("status bit", {31'h0, v}, {31'h0, status_word_out[b]});
  endtask
  task expect_sp(input logic [1:0] m, input logic [31:0] v);
    int i;
    cycles(4);
    for (i = 0; i < 40 && sp_valid_out !== 1'b1; i++)
      cycles(1);
    chk("sp valid", 32'h1, {31'h0, sp_valid_out});
    chk("sp mode", {30'h0, m}, {30'h0, sp_mode_out});
    chk("sp value", v, sp_value_out);
  endtask
  initial
  begin
    n_mismatch = 0;
    compares = 0;
    cyc = 0;
    rst_n_in = 1'b0;
    {obj_wr_in, obj_rd_in, quick_stop_in, closed_loop_in} = 4'h0;
    {obj_index_in, obj_sub_in, obj_wdata_in} = 56'h0;
    {act_pos_in, act_vel_in} = 64'h0;
    op_enabled_in = 1'b1;
    sp_ready_in = 1'b1;
    fb_en = 1'b1;
    fb_gap = MSC;
    repeat (4) @(posedge clock_in);
    #1;
    rst_n_in = 1'b1;
    chk("status reset", 32'h0, {16'h0, status_word_out});
    rdc(`CSM_IDX_MODE, `CSM_SUB_0, 32'h0);
    rdc(`CSM_IDX_IP_TIME, `CSM_SUB_1, 32'h1);
    wr(`CSM_IDX_IP_TIME, `CSM_SUB_2, 32'hfc, 1'b1);
    rdc(`CSM_IDX_IP_TIME, `CSM_SUB_2, 32'hfffffffd);
    wr(`CSM_IDX_ACT_POS, `CSM_SUB_0, 32'h5, 1'b1);
    wr(16'h1234, `CSM_SUB_0, 32'h0, 1'b1);
    act_pos_in = 32'h12345678;
    act_vel_in = 32'hfffffff9;
    rdc(`CSM_IDX_ACT_POS, `CSM_SUB_0, 32'h12345678);
    rdc(`CSM_IDX_ACT_VEL, `CSM_SUB_0, 32'hfffffff9);
    act_pos_in = 32'h0;
    wr(`CSM_IDX_SW_LIM, `CSM_SUB_2, 32'h64, 1'b0);
    wr(`CSM_IDX_POS_SP, `CSM_SUB_0, 32'hc8, 1'b0);
    wr(`CSM_IDX_POS_SP, `CSM_SUB_0, 32'hc8, 1'b0);
    wr(`CSM_IDX_MODE, `CSM_SUB_0, 32'h8, 1'b0);
    cycles(40);
    stat(`CSM_BIT_SYNC, 1'b1);
    stat(`CSM_BIT_FOLLOW, 1'b1);
    stat(`CSM_BIT_LIMIT, 1'b1);
    expect_sp(2'd1, 32'h64);
    wr(`CSM_IDX_CTRL, `CSM_SUB_0, 32'hffef, 1'b0);
    stat(`CSM_BIT_FOLLOW, 1'b1);
    wr(`CSM_IDX_POS_SP, `CSM_SUB_0, 32'h0, 1'b0);
    wr(`CSM_IDX_FE_WIN, `CSM_SUB_0, 32'h5, 1'b0);
    wr(`CSM_IDX_FE_TO, `CSM_SUB_0, 32'h2, 1'b0);
    act_pos_in = 32'h3;
    cycles(40);
    stat(`CSM_BIT_FERR, 1'b0);
    stat(`CSM_BIT_LIMIT, 1'b0);
    act_pos_in = 32'h64;
    cycles(15);
    stat(`CSM_BIT_FERR, 1'b0);
    cycles(40);
    stat(`CSM_BIT_FERR, 1'b1);
    rdc(`CSM_IDX_FE_ACT, `CSM_SUB_0, 32'h64);
    act_pos_in = 32'h0;
    cycles(2);
    stat(`CSM_BIT_FERR, 1'b0);
    wr(`CSM_IDX_RANGE, `CSM_SUB_1, 32'h0, 1'b0);
    wr(`CSM_IDX_RANGE, `CSM_SUB_2, 32'h3e7, 1'b0);
    wr(`CSM_IDX_POS_SP, `CSM_SUB_0, 32'h41a, 1'b0);
    expect_sp(2'd1, 32'h32);
    wr(`CSM_IDX_MAX_SPD, `CSM_SUB_0, 32'h3e8, 1'b0);
    wr(`CSM_IDX_VEL_SP, `CSM_SUB_0, 32'hfffff830, 1'b0);
    wr(`CSM_IDX_MODE, `CSM_SUB_0, 32'h9, 1'b0);
    expect_sp(2'd2, 32'hfffffc18);
    wr(`CSM_IDX_MAX_TRQ, `CSM_SUB_0, 32'h32, 1'b0);
    wr(`CSM_IDX_MAX_CUR, `CSM_SUB_0, 32'h1e, 1'b0);
    wr(`CSM_IDX_TRQ_SP, `CSM_SUB_0, 32'hff9c, 1'b0);
    wr(`CSM_IDX_MODE, `CSM_SUB_0, 32'ha, 1'b0);
    cycles(30);
    stat(`CSM_BIT_FOLLOW, 1'b0);
    closed_loop_in = 1'b1;
    expect_sp(2'd3, 32'hffffffe2);
    wr(`CSM_IDX_QS_DEC, `CSM_SUB_0, 32'h1234, 1'b0);
    wr(`CSM_IDX_QS_OPT, `CSM_SUB_0, 32'h2, 1'b0);
    quick_stop_in = 1'b1;
    cycles(1);
    chk("qs decel", 32'h1234, qs_decel_out);
    chk("qs option", 32'h2, {16'h0, qs_option_out});
    stat(`CSM_BIT_FOLLOW, 1'b0);
    quick_stop_in = 1'b0;
    op_enabled_in = 1'b0;
    cycles(1);
    stat(`CSM_BIT_FOLLOW, 1'b0);
    op_enabled_in = 1'b1;
    fb_en = 1'b0;
    cycles(40);
    stat(`CSM_BIT_SYNC, 1'b0);
    fb_gap = 2 * MSC;
    wr(`CSM_IDX_IP_TIME, `CSM_SUB_1, 32'h2, 1'b0);
    fb_en = 1'b1;
    cycles(100);
    stat(`CSM_BIT_SYNC, 1'b1);
    sp_ready_in = 1'b0;
    cycles(100);
    chk("sp held", 32'h1, {31'h0, sp_valid_out});
    chk("sp held value", 32'hffffffe2, sp_value_out);
    fb_en = 1'b0;
    sp_ready_in = 1'b1;
    cycles(10);
    chk("sp drained", 32'h0, {31'h0, sp_valid_out});
    report_and_stop();
  end
endmodule
